// >>> common/thl_pkg.sv
// Package for the two-wire high-level controller register layer
// Contract
// - Command write with slave-only clear launches master transfer or core register access.
// - Command write with slave-only set launches nothing; all command fields except opcode and read bit still update.
// - Valid flag set by every write; cleared by completions or remote read.
// - Remote reads command register; valid only with valid flag and slave-only.
// - Opcode decodes addressing width, byte size, transfer form, clock and extended access.
// - Opcode 0110 extra opcode picks slave addr, data, control, ext addr, reset.
// - Extra opcode 011 selects clock control on write, status on read.
// - Read bit picks direction on launch; reads back last master transfer result.
// - Size override takes length from size field, coded as length minus one.
// - Ten-bit remote address gives slave address; top bits only for 10-bit.
// - Internal address byte is internal address field over extra opcode bits.
// - Extended internal address flag sends extension address byte first.
// - Data field holds last write, then master completion code or configuration read result.
// - Scratch bits keep whatever software last wrote.
// - Mailbox valid bits set to 11 by remote write, cleared by software read.
// - Remote writes mailbox with one or four bytes; valid only when 11.
// - Mailbox interrupt source set on every remote mailbox write.
// - Write-path interrupt source set whenever command valid flag clears.
// - Update sources clear on write of one; core source is read-only.
// - Enabling controller clears core enable; disabling clears both update enables.
// - Live line levels readable; override bits pull the line low.
// - Extension data supplies bytes five to eight of master transfers.
// - Core soft reset access returns core idle and clears its flags.
package thl_pkg;
  localparam logic [63:0] ADDR_CMD = 64'h0001180000001000;
  localparam logic [63:0] ADDR_MBOX = 64'h0001180000001008;
  localparam logic [63:0] ADDR_INT = 64'h0001180000001010;
  localparam logic [63:0] ADDR_EXT = 64'h0001180000001018;
  localparam int CMD_V = 63;
  localparam int CMD_SLAVE_ONLY_MODE = 62;
  localparam int CMD_EIA = 61;
  localparam int CMD_OP_LO = 57;
  localparam int CMD_RD = 56;
  localparam int CMD_SIZE_OVERRIDE = 55;
  localparam int CMD_SIZE_LO = 52;
  localparam int CMD_SCR_LO = 50;
  localparam int CMD_ADDR_LO = 40;
  localparam int CMD_IA_LO = 35;
  localparam int CMD_EOP_LO = 32;
  localparam int INT_SCL = 11;
  localparam int INT_SDA = 10;
  localparam int INT_CLOCK_LINE_OVERRIDE = 9;
  localparam int INT_DATA_LINE_OVERRIDE = 8;
  localparam int INT_CORE_EN = 6;
  localparam int INT_MAILBOX_IRQ_ENABLE = 5;
  localparam int INT_WRITE_PATH_IRQ_ENABLE = 4;
  localparam int INT_CORE = 2;
  localparam int INT_TS = 1;
  localparam int INT_ST = 0;
  localparam int EXT_IA_LO = 32;
  localparam logic [3:0] OP_CLK = 4'h4;
  localparam logic [3:0] OP_EXT = 4'h6;
  localparam logic [1:0] MBOX_FULL = 2'h3;
  localparam logic [1:0] MBOX_EMPTY = 2'h0;
  localparam logic [2:0] LEN_ONE = 3'h0;
  localparam logic [2:0] LEN_FOUR = 3'h3;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  typedef enum logic [2:0] {
    THL_SLV_ADDR, THL_DATA, THL_CTRL, THL_CLK_OR_STAT,
    THL_EXT_SLV, THL_RSV5, THL_RSV6, THL_SOFT_RST
  } thl_eop_t;
  typedef enum logic [3:0] {
    THL_REG_SLV_ADDR, THL_REG_DATA, THL_REG_CTRL, THL_REG_CLK_CTRL, THL_REG_STATUS,
    THL_REG_EXT_SLV, THL_REG_SOFT_RST, THL_REG_MASTER_CLK, THL_REG_NONE
  } thl_core_reg_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] addr;
    logic [63:0] wdata;
  } thl_csr_req_t;
  typedef struct packed {
    logic ten_bit;
    logic read;
    logic with_ia;
    logic ext_ia;
    logic [2:0] len_m1;
    logic [9:0] addr;
    logic [7:0] ia;
    logic [7:0] ext_ia_byte;
    logic [63:0] data;
  } thl_mst_cmd_t;
  typedef struct packed {
    thl_core_reg_t sel;
    logic read;
    logic [7:0] wdata;
  } thl_cfg_cmd_t;
  typedef struct packed {
    logic mst_done;
    logic mst_ok;
    logic [31:0] mst_code;
    logic cfg_done;
    logic [7:0] cfg_rdata;
  } thl_core_rsp_t;
  typedef struct packed {
    logic rd_cmd;
    logic wr_mbox;
    logic four_byte;
    logic [31:0] wdata;
  } thl_rmt_t;
  typedef struct packed {
    logic is_master;
    logic is_cfg;
    logic ten_bit;
    logic four_byte;
    logic with_ia;
  } thl_op_t;
endpackage

// >>> logic/thl_regs.sv
// Register layer of the two-wire high-level controller
`timescale 1ns/1ns
module thl_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire thl_pkg::thl_csr_req_t csr_req_in,
  output logic csr_rsp_out,
  output logic [63:0] csr_rdata_out,
  output logic mst_req_out,
  output thl_pkg::thl_mst_cmd_t mst_cmd_out,
  output logic cfg_req_out,
  output thl_pkg::thl_cfg_cmd_t cfg_cmd_out,
  input wire thl_pkg::thl_core_rsp_t core_rsp_in,
  input wire logic core_irq_in,
  input wire logic hlc_enable_in,
  input wire thl_pkg::thl_rmt_t rmt_in,
  output logic cmd_valid_out,
  output logic [31:0] cmd_data_out,
  output logic [33:0] mbox_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);
  // Opcode layout: bit3 four bytes, bit1 ten-bit, bit0 combined or with address
  function automatic thl_pkg::thl_op_t decode_op(input logic [3:0] op);
    thl_pkg::thl_op_t d;
    d = '0;
    d.is_master = !op[2];
    d.is_cfg = (op == thl_pkg::OP_CLK) || (op == thl_pkg::OP_EXT);
    d.ten_bit = op[1];
    d.four_byte = op[3];
    d.with_ia = op[0];
    return d;
  endfunction

  function automatic thl_pkg::thl_core_reg_t decode_eop(input logic [2:0] eop, input logic rd);
    thl_pkg::thl_core_reg_t r;
    case (thl_pkg::thl_eop_t'(eop))
      thl_pkg::THL_SLV_ADDR: r = thl_pkg::THL_REG_SLV_ADDR;
      thl_pkg::THL_DATA: r = thl_pkg::THL_REG_DATA;
      thl_pkg::THL_CTRL: r = thl_pkg::THL_REG_CTRL;
      thl_pkg::THL_CLK_OR_STAT: r = rd ? thl_pkg::THL_REG_STATUS : thl_pkg::THL_REG_CLK_CTRL;
      thl_pkg::THL_EXT_SLV: r = thl_pkg::THL_REG_EXT_SLV;
      thl_pkg::THL_SOFT_RST: r = thl_pkg::THL_REG_SOFT_RST;
      default: r = thl_pkg::THL_REG_NONE;
    endcase
    return r;
  endfunction

  logic sw_v;
  logic slave_only_mode;
  logic extended_int_addr_enable;
  logic result;
  logic size_override;
  logic [2:0] size;
  logic [1:0] scratch_bits;
  logic [9:0] raddr;
  logic [4:0] ia;
  logic [2:0] eop;
  logic [31:0] data;
  logic [7:0] ext_ia;
  logic [31:0] ext_d;
  logic [1:0] mb_v;
  logic [31:0] mb_d;
  logic core_en;
  logic mailbox_irq_enable;
  logic write_path_irq_enable;
  logic mailbox_irq_source;
  logic write_path_irq_source;
  logic core_int;
  logic hlc_q;
  logic cfg_rd_pend;
  logic bad_op;
  logic scl_s1;
  logic scl_s2;
  logic sda_s1;
  logic sda_s2;

  logic [63:0] wd;
  logic wr_cmd;
  logic wr_int;
  logic wr_ext;
  logic rd_mbox;
  logic launch;
  thl_pkg::thl_op_t op_d;
  thl_pkg::thl_core_reg_t sel_d;
  logic clr_v;
  logic v_fall;

  assign wd = csr_req_in.wdata;
  assign wr_cmd = csr_req_in.valid && csr_req_in.write && csr_req_in.addr == thl_pkg::ADDR_CMD;
  assign wr_int = csr_req_in.valid && csr_req_in.write && csr_req_in.addr == thl_pkg::ADDR_INT;
  assign wr_ext = csr_req_in.valid && csr_req_in.write && csr_req_in.addr == thl_pkg::ADDR_EXT;
  assign rd_mbox = csr_req_in.valid && !csr_req_in.write
    && csr_req_in.addr == thl_pkg::ADDR_MBOX;
  assign launch = wr_cmd && !wd[thl_pkg::CMD_SLAVE_ONLY_MODE];
  assign op_d = decode_op(wd[thl_pkg::CMD_OP_LO +: 4]);
  assign sel_d = (wd[thl_pkg::CMD_OP_LO +: 4] == thl_pkg::OP_CLK) ? thl_pkg::THL_REG_MASTER_CLK
    : decode_eop(wd[thl_pkg::CMD_EOP_LO +: 3], wd[thl_pkg::CMD_RD]);
  assign clr_v = core_rsp_in.mst_done || core_rsp_in.cfg_done || bad_op
    || (slave_only_mode && rmt_in.rd_cmd);
  assign v_fall = sw_v && clr_v && !wr_cmd;

  // Line inputs come from the pins, so they are synchronised first
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  // valid flag, software write wins over a same-cycle clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sw_v <= 1'b0;
    end else if (wr_cmd) begin
      sw_v <= 1'b1;
    end else if (clr_v) begin
      sw_v <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slave_only_mode <= 1'b0;
      extended_int_addr_enable <= 1'b0;
      size_override <= 1'b0;
      size <= '0;
      scratch_bits <= '0;
      raddr <= '0;
      ia <= '0;
      eop <= '0;
    end else if (wr_cmd) begin
      slave_only_mode <= wd[thl_pkg::CMD_SLAVE_ONLY_MODE];
      extended_int_addr_enable <= wd[thl_pkg::CMD_EIA];
      size_override <= wd[thl_pkg::CMD_SIZE_OVERRIDE];
      size <= wd[thl_pkg::CMD_SIZE_LO +: 3];
      scratch_bits <= wd[thl_pkg::CMD_SCR_LO +: 2];
      raddr <= wd[thl_pkg::CMD_ADDR_LO +: 10];
      ia <= wd[thl_pkg::CMD_IA_LO +: 5];
      eop <= wd[thl_pkg::CMD_EOP_LO +: 3];
    end
  end

  // data field: write, then completion code or config read result
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data <= thl_pkg::DATA_RST;
    end else if (wr_cmd) begin
      data <= wd[31:0];
    end else if (core_rsp_in.mst_done) begin
      data <= core_rsp_in.mst_code;
    end else if (core_rsp_in.cfg_done && cfg_rd_pend) begin
      data <= {24'h000000, core_rsp_in.cfg_rdata};
    end
  end

  // result of the most recent master transfer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result <= 1'b0;
    end else if (core_rsp_in.mst_done) begin
      result <= core_rsp_in.mst_ok;
    end else if (bad_op) begin
      result <= 1'b0;
    end
  end

  // extension address byte and upper data bytes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_ia <= '0;
      ext_d <= '0;
    end else if (wr_ext) begin
      ext_ia <= wd[thl_pkg::EXT_IA_LO +: 8];
      ext_d <= wd[31:0];
    end
  end

  // Unused opcodes complete at once as failures; unused extra opcodes 5 and 6 launch nothing and leave valid set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bad_op <= 1'b0;
    end else begin
      bad_op <= launch && !op_d.is_master && !op_d.is_cfg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mst_req_out <= 1'b0;
      mst_cmd_out <= '0;
    end else begin
      mst_req_out <= launch && op_d.is_master;
      if (launch && op_d.is_master) begin
        mst_cmd_out.ten_bit <= op_d.ten_bit;
        mst_cmd_out.read <= wd[thl_pkg::CMD_RD];
        mst_cmd_out.with_ia <= op_d.with_ia;
        mst_cmd_out.ext_ia <= op_d.with_ia && wd[thl_pkg::CMD_EIA];
        mst_cmd_out.len_m1 <= wd[thl_pkg::CMD_SIZE_OVERRIDE] ? wd[thl_pkg::CMD_SIZE_LO +: 3]
          : (op_d.four_byte ? thl_pkg::LEN_FOUR : thl_pkg::LEN_ONE);
        mst_cmd_out.addr <= wd[thl_pkg::CMD_ADDR_LO +: 10];
        mst_cmd_out.ia <= {wd[thl_pkg::CMD_IA_LO +: 5], wd[thl_pkg::CMD_EOP_LO +: 3]};
        mst_cmd_out.ext_ia_byte <= ext_ia;
        mst_cmd_out.data <= {ext_d, wd[31:0]};
      end
    end
  end

  // core register access, soft reset included
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_req_out <= 1'b0;
      cfg_cmd_out <= '{sel: thl_pkg::THL_REG_NONE, read: 1'b0, wdata: 8'h00};
      cfg_rd_pend <= 1'b0;
    end else begin
      cfg_req_out <= launch && op_d.is_cfg && sel_d != thl_pkg::THL_REG_NONE;
      if (launch && op_d.is_cfg) begin
        cfg_cmd_out.sel <= sel_d;
        cfg_cmd_out.read <= wd[thl_pkg::CMD_RD];
        cfg_cmd_out.wdata <= wd[7:0];
      end
      if (launch && op_d.is_cfg) begin
        cfg_rd_pend <= wd[thl_pkg::CMD_RD];
      end else if (core_rsp_in.cfg_done) begin
        cfg_rd_pend <= 1'b0;
      end
    end
  end

  // mailbox, remote write wins over software read clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mb_v <= thl_pkg::MBOX_EMPTY;
      mb_d <= '0;
    end else if (rmt_in.wr_mbox) begin
      mb_v <= thl_pkg::MBOX_FULL;
      mb_d <= rmt_in.four_byte ? rmt_in.wdata : {mb_d[31:8], rmt_in.wdata[7:0]};
    end else if (rd_mbox) begin
      mb_v <= thl_pkg::MBOX_EMPTY;
    end
  end

  // enables, controller edges override a same-cycle write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hlc_q <= hlc_enable_in;
      core_en <= 1'b0;
      mailbox_irq_enable <= 1'b0;
      write_path_irq_enable <= 1'b0;
    end else begin
      hlc_q <= hlc_enable_in;
      if (hlc_enable_in && !hlc_q) begin
        core_en <= 1'b0;
      end else if (wr_int) begin
        core_en <= wd[thl_pkg::INT_CORE_EN];
      end
      if (!hlc_enable_in && hlc_q) begin
        mailbox_irq_enable <= 1'b0;
        write_path_irq_enable <= 1'b0;
      end else if (wr_int) begin
        mailbox_irq_enable <= wd[thl_pkg::INT_MAILBOX_IRQ_ENABLE];
        write_path_irq_enable <= wd[thl_pkg::INT_WRITE_PATH_IRQ_ENABLE];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mailbox_irq_source <= 1'b0;
      write_path_irq_source <= 1'b0;
      core_int <= 1'b0;
    end else begin
      core_int <= core_irq_in;
      if (rmt_in.wr_mbox) begin
        mailbox_irq_source <= 1'b1;
      end else if (wr_int && wd[thl_pkg::INT_TS]) begin
        mailbox_irq_source <= 1'b0;
      end
      if (v_fall) begin
        write_path_irq_source <= 1'b1;
      end else if (wr_int && wd[thl_pkg::INT_ST]) begin
        write_path_irq_source <= 1'b0;
      end
    end
  end

  // the controller setting decides which sources count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= hlc_enable_in ? ((mailbox_irq_source && mailbox_irq_enable) || (write_path_irq_source && write_path_irq_enable))
        : (core_int && core_en);
    end
  end

  // override pulls the line low through its open-drain driver
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (wr_int) begin
      scl_oe_out <= wd[thl_pkg::INT_CLOCK_LINE_OVERRIDE];
      sda_oe_out <= wd[thl_pkg::INT_DATA_LINE_OVERRIDE];
    end
  end

  // view for the remote slave engine
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_data_out <= '0;
      mbox_out <= '0;
    end else begin
      cmd_valid_out <= sw_v && slave_only_mode && !clr_v;
      cmd_data_out <= data;
      mbox_out <= {mb_v, mb_d};
    end
  end

  // Register read port, answer one cycle after the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      csr_rsp_out <= 1'b0;
      csr_rdata_out <= '0;
    end else begin
      csr_rsp_out <= csr_req_in.valid;
      csr_rdata_out <= '0;
      if (csr_req_in.valid && !csr_req_in.write) begin
        case (csr_req_in.addr)
          // opcode fields read back as zero, read bit shows the result
          thl_pkg::ADDR_CMD: csr_rdata_out <= {sw_v, slave_only_mode, extended_int_addr_enable, 4'h0, result, size_override, size,
            scratch_bits, raddr, ia, 3'h0, data};
          thl_pkg::ADDR_MBOX: csr_rdata_out <= {mb_v, 30'h00000000, mb_d};
          thl_pkg::ADDR_INT: csr_rdata_out <= {52'h0, scl_s2, sda_s2, scl_oe_out, sda_oe_out,
            1'b0, core_en, mailbox_irq_enable, write_path_irq_enable, 1'b0, core_int, mailbox_irq_source, write_path_irq_source};
          thl_pkg::ADDR_EXT: csr_rdata_out <= {24'h000000, ext_ia, ext_d};
          default: csr_rdata_out <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_LAUNCH: assert property (launch && op_d.is_master |=> mst_req_out)
    else $error("master launch missing");
  AST_SLAVE_ONLY_MODE: assert property (wr_cmd && wd[thl_pkg::CMD_SLAVE_ONLY_MODE]
    |=> !mst_req_out && !cfg_req_out && !bad_op)
    else $error("slave-only write launched");
  AST_VSET: assert property (wr_cmd |=> sw_v)
    else $error("valid not set");
  AST_CLKSTAT: assert property (launch && wd[thl_pkg::CMD_OP_LO +: 4] == thl_pkg::OP_EXT
    && wd[thl_pkg::CMD_EOP_LO +: 3] == 3'h3 |=> cfg_req_out
    && cfg_cmd_out.sel == ($past(wd[thl_pkg::CMD_RD]) ? thl_pkg::THL_REG_STATUS
    : thl_pkg::THL_REG_CLK_CTRL))
    else $error("clock/status select wrong");
  AST_RESULT: assert property (core_rsp_in.mst_done
    |=> result == $past(core_rsp_in.mst_ok) && data == $past(core_rsp_in.mst_code))
    else $error("completion not captured");
  AST_SIZE: assert property (launch && op_d.is_master && wd[thl_pkg::CMD_SIZE_OVERRIDE]
    |=> mst_cmd_out.len_m1 == $past(wd[thl_pkg::CMD_SIZE_LO +: 3]))
    else $error("size override ignored");
  AST_IA: assert property (launch && op_d.is_master |=> mst_cmd_out.ia
    == {$past(wd[thl_pkg::CMD_IA_LO +: 5]), $past(wd[thl_pkg::CMD_EOP_LO +: 3])})
    else $error("internal address byte wrong");
  AST_MBOX: assert property (rmt_in.wr_mbox |=> mb_v == thl_pkg::MBOX_FULL && mailbox_irq_source
    ##1 mbox_out[33:32] == thl_pkg::MBOX_FULL)
    else $error("mailbox write not flagged");
  AST_STINT: assert property ($fell(sw_v) |-> write_path_irq_source)
    else $error("write-path source not set");
  AST_HLC: assert property ($rose(hlc_enable_in) |=> !core_en)
    else $error("core enable not cleared");
  AST_OVR: assert property (wr_int && wd[thl_pkg::INT_CLOCK_LINE_OVERRIDE] |=> scl_oe_out && !scl_out)
    else $error("clock override not driven");

  COV_MASTER: cover property (mst_req_out ##[1:50] core_rsp_in.mst_done);
  COV_CFG_RD: cover property (cfg_req_out && cfg_cmd_out.read ##[1:50] core_rsp_in.cfg_done);
  COV_SLAVE_ONLY_MODE_RD: cover property (sw_v && slave_only_mode && rmt_in.rd_cmd);
  COV_MBOX: cover property (rmt_in.wr_mbox ##[1:20] rd_mbox);
endmodule

// >>> verif/thl_far_side.sv
// Far-side model: low-level core answers and a remote bus device
`timescale 1ns/1ns
module thl_far_side (
  input wire logic clk_in,
  input wire logic mst_req_in,
  input wire thl_pkg::thl_mst_cmd_t mst_cmd_in,
  input wire logic cfg_req_in,
  input wire thl_pkg::thl_cfg_cmd_t cfg_cmd_in,
  output thl_pkg::thl_core_rsp_t core_rsp_out,
  output thl_pkg::thl_rmt_t rmt_out
);
  int dly = 3;
  int mcnt = 0;
  int ccnt = 0;
  logic ok = 1'b1;
  logic [7:0] stat = 8'h08;
  initial core_rsp_out = '0;
  initial rmt_out = '0;
  // Delay is set by the bench so answers come both promptly and slowly
  always @(negedge clk_in) begin
    core_rsp_out.mst_done <= 1'b0;
    core_rsp_out.cfg_done <= 1'b0;
    if (mst_req_in) begin
      mcnt <= dly;
    end else if (mcnt != 0) begin
      mcnt <= mcnt - 1;
      if (mcnt == 1) begin
        core_rsp_out <= {1'b1, ok, 22'h0, mst_cmd_in.addr, 1'b0, core_rsp_out.cfg_rdata};
      end
    end
    if (cfg_req_in) begin
      ccnt <= dly;
    end else if (ccnt != 0) begin
      ccnt <= ccnt - 1;
      if (ccnt == 1) begin
        core_rsp_out.cfg_done <= 1'b1;
        core_rsp_out.cfg_rdata <= (cfg_cmd_in.sel == thl_pkg::THL_REG_STATUS) ? stat : 8'h5A;
        if (cfg_cmd_in.sel == thl_pkg::THL_REG_SOFT_RST) stat <= 8'hF8;
      end
    end
  end
  task automatic remote_read();
    @(negedge clk_in);
    rmt_out.rd_cmd <= 1'b1;
    @(negedge clk_in);
    rmt_out.rd_cmd <= 1'b0;
  endtask
  task automatic remote_write(input logic four, input logic [31:0] d);
    @(negedge clk_in);
    rmt_out <= {1'b0, 1'b1, four, d};
    @(negedge clk_in);
    rmt_out.wr_mbox <= 1'b0;
    // Released data no longer shows the last value
    rmt_out.wdata <= ~d;
  endtask
endmodule

// >>> verif/thl_regs_tb.sv
// Self-checking bench for the two-wire controller register layer
`timescale 1ns/1ns
module thl_regs_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hlc_enable_in = 1'b1;
  logic core_irq_in = 1'b0;
  logic line_clk = 1'b1;
  logic link_on = 1'b0;
  logic mreq, creq, csr_rsp_out, mst_req_out, cfg_req_out, cmd_valid_out, irq_out;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, scl_in, sda_in;
  logic [63:0] csr_rdata_out;
  logic [31:0] cmd_data_out;
  logic [33:0] mbox_out;
  int num_errors = 0;
  int samples_checked = 0;
  thl_pkg::thl_csr_req_t csr_req_in = '0;
  thl_pkg::thl_mst_cmd_t mst_cmd_out;
  thl_pkg::thl_cfg_cmd_t cfg_cmd_out;
  thl_pkg::thl_core_rsp_t core_rsp_in;
  thl_pkg::thl_rmt_t rmt_in;
  // Pulled-up open-drain lines; the remote clock runs only within frames
  assign scl_in = line_clk & ~scl_oe_out;
  assign sda_in = ~sda_oe_out;
  always #5 clk_in = ~clk_in;
  always #40 if (link_on) line_clk = ~line_clk;
  thl_regs dut (.clk_in(clk_in), .rst_in(rst_in), .csr_req_in(csr_req_in),
    .csr_rsp_out(csr_rsp_out), .csr_rdata_out(csr_rdata_out), .mst_req_out(mst_req_out),
    .mst_cmd_out(mst_cmd_out), .cfg_req_out(cfg_req_out), .cfg_cmd_out(cfg_cmd_out),
    .core_rsp_in(core_rsp_in), .core_irq_in(core_irq_in), .hlc_enable_in(hlc_enable_in),
    .rmt_in(rmt_in), .cmd_valid_out(cmd_valid_out), .cmd_data_out(cmd_data_out),
    .mbox_out(mbox_out), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));
  thl_far_side far (.clk_in(clk_in), .mst_req_in(mst_req_out), .mst_cmd_in(mst_cmd_out),
    .cfg_req_in(cfg_req_out), .cfg_cmd_in(cfg_cmd_out), .core_rsp_out(core_rsp_in),
    .rmt_out(rmt_in));
  task automatic end_of_test();
    $display("TB: %0d checks, %0d errors", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A missing answer shows up as an impossible read value
  task automatic csr(input logic w, input logic [63:0] a, input logic [63:0] d,
                     output logic [63:0] q);
    @(negedge clk_in);
    csr_req_in <= {1'b1, w, a, d};
    @(negedge clk_in);
    csr_req_in.valid <= 1'b0;
    q = csr_rsp_out ? csr_rdata_out : 64'hBAD0_BAD0_BAD0_BAD0;
    mreq = mst_req_out;
    creq = cfg_req_out;
  endtask
  task automatic wr(input logic [63:0] a, input logic [63:0] d);
    logic [63:0] q;
    csr(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [63:0] a, input logic [63:0] e, input logic [63:0] m = '1);
    logic [63:0] q;
    csr(1'b0, a, 64'h0, q);
    chk(q & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wait_idle();
    logic [63:0] q;
    int n;
    n = 0;
    do begin
      csr(1'b0, thl_pkg::ADDR_CMD, 64'h0, q);
      n++;
    end while (q[63] !== 1'b0 && n < 60);
    if (q[63] !== 1'b0) num_errors++;
  endtask
  function automatic logic [63:0] mk(input logic [3:0] op, input logic [2:0] eop,
                                     input logic r, input logic [9:0] a, input logic [31:0] d);
    return {3'b100, op, r, 1'b0, 3'h0, 2'h0, a, 5'h0, eop, d};
  endfunction
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    logic [3:0] ops [5] = '{4'h0, 4'h1, 4'h8, 4'hA, 4'h3};
    logic [4:0] fmt [5] = '{5'h00, 5'h08, 5'h03, 5'h13, 5'h18};
    logic [3:0] cops [9] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h4, 4'h6};
    logic [2:0] ceop [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h7, 3'h0, 3'h3};
    logic crd [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    thl_pkg::thl_core_reg_t csel [9] = '{thl_pkg::THL_REG_SLV_ADDR, thl_pkg::THL_REG_DATA,
      thl_pkg::THL_REG_CTRL, thl_pkg::THL_REG_CLK_CTRL, thl_pkg::THL_REG_EXT_SLV,
      thl_pkg::THL_REG_STATUS, thl_pkg::THL_REG_SOFT_RST, thl_pkg::THL_REG_MASTER_CLK,
      thl_pkg::THL_REG_STATUS};
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    rd(thl_pkg::ADDR_INT, 64'h0, 64'hFFFF_FFFF_FFFF_F3FF);
    rd(thl_pkg::ADDR_MBOX, 64'h0);
    rd(thl_pkg::ADDR_EXT, 64'h0);
    wr(64'h0001_1800_0000_1020, '1);
    for (int i = 0; i < 5; i++) begin
      far.ok = ~i[0];
      far.dly = 2 + 9 * i;
      wr(thl_pkg::ADDR_CMD, mk(ops[i], 3'h0, i[0], 10'h2A5 + i[9:0], 32'h1234_5670));
      chk({63'h0, mreq}, 64'h1);
      chk({mst_cmd_out.ten_bit, mst_cmd_out.with_ia, mst_cmd_out.len_m1}, fmt[i]);
      chk({mst_cmd_out.read, mst_cmd_out.addr}, {i[0], 10'h2A5 + i[9:0]});
      wait_idle();
      rd(thl_pkg::ADDR_CMD, {7'h0, ~i[0], 46'h0, 10'h2A5 + i[9:0]},
         64'h8100_0000_FFFF_FFFF);
      rd(thl_pkg::ADDR_INT, 64'h1, 64'h1);
      wr(thl_pkg::ADDR_INT, 64'h3);
      rd(thl_pkg::ADDR_INT, 64'h0, 64'h1);
    end
    // Unused opcode launches nothing and completes at once as a failure
    wr(thl_pkg::ADDR_CMD, mk(4'hC, 3'h0, 1'b1, 10'h0, 32'h0));
    chk({62'h0, mreq, creq}, 64'h0);
    wait_idle();
    rd(thl_pkg::ADDR_CMD, 64'h0, 64'h8100_0000_0000_0000);
    far.ok = 1'b0;
    wr(thl_pkg::ADDR_EXT, 64'h0000_00C3_CAFE_F00D);
    wr(thl_pkg::ADDR_CMD, mk(4'hB, 3'h5, 1'b0, 10'h3C1, 32'h0102_0304) | 64'h20F8_0088_0000_0000);
    chk({mst_cmd_out.len_m1, mst_cmd_out.ten_bit, mst_cmd_out.with_ia}, 64'h1F);
    chk({mst_cmd_out.ext_ia, mst_cmd_out.ext_ia_byte, mst_cmd_out.ia}, 64'h1C38D);
    chk(mst_cmd_out.data, 64'hCAFE_F00D_0102_0304);
    wait_idle();
    rd(thl_pkg::ADDR_CMD, 64'h0008_0000_0000_03C1, 64'h010C_0000_FFFF_FFFF);
    far.dly = 4;
    for (int i = 0; i < 9; i++) begin
      wr(thl_pkg::ADDR_CMD, mk(cops[i], ceop[i], crd[i], 10'h0, 32'hA0 + i));
      chk({63'h0, creq}, 64'h1);
      chk({cfg_cmd_out.sel, cfg_cmd_out.read}, {csel[i], crd[i]});
      chk(cfg_cmd_out.wdata, 8'hA0 + i[7:0]);
      wait_idle();
      rd(thl_pkg::ADDR_CMD, crd[i] ? ((i == 8) ? 64'hF8 : 64'h08) : 64'hA0 + i,
         64'hFFFF_FFFF);
    end
    wr(thl_pkg::ADDR_INT, 64'h3);
    wr(thl_pkg::ADDR_CMD, 64'hC000_0000_5555_AAAA);
    chk({62'h0, mreq, creq}, 64'h0);
    cyc(1);
    chk({cmd_valid_out, cmd_data_out}, 64'h1_5555_AAAA);
    far.remote_read();
    cyc(1);
    chk({63'h0, cmd_valid_out}, 64'h0);
    rd(thl_pkg::ADDR_INT, 64'h1, 64'h1);
    wr(thl_pkg::ADDR_INT, 64'h33);
    link_on = 1'b1;
    far.remote_write(1'b1, 32'hDEAD_BEEF);
    cyc(1);
    chk({63'h0, irq_out}, 64'h1);
    chk({30'h0, mbox_out}, 64'h3_DEAD_BEEF);
    rd(thl_pkg::ADDR_MBOX, 64'hC000_0000_DEAD_BEEF);
    rd(thl_pkg::ADDR_MBOX, 64'h0000_0000_DEAD_BEEF);
    far.remote_write(1'b0, 32'h0000_0077);
    rd(thl_pkg::ADDR_MBOX, 64'hC000_0000_DEAD_BE77);
    wr(thl_pkg::ADDR_MBOX, 64'hC000_0000_0000_0000);
    rd(thl_pkg::ADDR_MBOX, 64'h0, 64'hC000_0000_0000_0000);
    rd(thl_pkg::ADDR_INT, 64'h2, 64'h2);
    wr(thl_pkg::ADDR_INT, 64'h32);
    cyc(1);
    chk({63'h0, irq_out}, 64'h0);
    @(posedge line_clk);
    link_on = 1'b0;
    cyc(1);
    hlc_enable_in = 1'b0;
    cyc(2);
    rd(thl_pkg::ADDR_INT, 64'h0, 64'h70);
    wr(thl_pkg::ADDR_INT, 64'h40);
    core_irq_in = 1'b1;
    cyc(3);
    chk({63'h0, irq_out}, 64'h1);
    rd(thl_pkg::ADDR_INT, 64'h44, 64'h74);
    hlc_enable_in = 1'b1;
    cyc(3);
    rd(thl_pkg::ADDR_INT, 64'h04, 64'h74);
    chk({63'h0, irq_out}, 64'h0);
    core_irq_in = 1'b0;
    wr(thl_pkg::ADDR_INT, 64'h300);
    cyc(1);
    chk({60'h0, scl_oe_out, scl_out, sda_oe_out, sda_out}, 64'hA);
    cyc(3);
    rd(thl_pkg::ADDR_INT, 64'h300, 64'hF00);
    wr(thl_pkg::ADDR_INT, 64'h0);
    cyc(4);
    rd(thl_pkg::ADDR_INT, 64'hC00, 64'hF00);
    end_of_test();
  end
endmodule
